// ---- src/asu_serial_regs.sv ----
// asynchronous serial unit: registers, baud timer, transmitter, receiver
//
// What this block does
// RL1: unqueued: half-room rises when holding moves out
// RL2: drained flag rises as stop bit starts
// RL3: unqueued: has-entry rises when frame lands
// RL4: software waits drained flag ending a block
// RL5: queued driver writes sixteen, then eight more
// RL6: queued: half-level flag at eight held entries
// RL7: idle gap raises one of two timeout flags
// RL8: baud read gives count, write loads reload
// RL9: baud write reloads timer, deferred until run
// RL10: transmit holding write starts a character
// RL11: parity bit generated, written value ignored
// RL12: software writes bit 8 zero, eight-bit format
// RL13: receive bit 9 framing error, upper zero
// RL14: receive bits 8 and 7 follow format
// RL15: run clear freezes engines, line high
// RL16: config bits run, receiver on, queue mode
// RL17: loopback changed only while unit inactive
// RL18: parity select even or odd
// RL19: stop length half, one, one-half, two
// RL20: format codes for data, parity, wake-up
// RL21: software avoids reserved format codes
// RL22: baud tick is clock over divider
// RL23: irq high when flag and mask both set
// RL24: gap counter reloads or counts down
// RL25: 16-bit registers, word offsets, reserved zero
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "asu_map.svh"
module asu_serial_regs #(
  parameter int DEPTH = 16
) (
  input  wire logic        pclk,           // bus clock, 20 MHz
  input  wire logic        presetn,        // async reset, low active
  input  wire logic        ce,             // clock enable, freezes all state
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb direction
  input  wire logic [11:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error, unmapped address
  input  wire logic        rxd,            // serial input line
  output logic             txd,            // serial output line
  output logic             serial_irq_out  // flag and mask combined
);
  initial begin
    if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two from 2 to 16");
    end
  end

  localparam logic [3:0] AMASK = 4'(DEPTH - 1);
  localparam logic [4:0] QFULL = 5'(DEPTH);

  asu_pkg::asu_state_s s, n;
  logic [8:0]  tx_head;
  logic [9:0]  rx_head_w;
  asu_pkg::asu_rx_entry_s rx_head, rx_new;
  logic        rx_push;

  // decoded config fields
  logic       run, rx_on, queued, loop, odd;
  logic [1:0] stop_sel;
  logic [2:0] mode;
  assign run      = s.cfg[`ASU_CFG_RUN];       // [RL16]
  assign rx_on    = s.cfg[`ASU_CFG_RXON];      // [RL16]
  assign queued   = s.cfg[`ASU_CFG_QUEUE];     // [RL16]
  assign loop     = s.cfg[`ASU_CFG_LOOP];
  assign odd      = s.cfg[`ASU_CFG_ODD];
  assign stop_sel = s.cfg[`ASU_CFG_STOP_HI:`ASU_CFG_STOP_LO];
  assign mode     = s.cfg[`ASU_CFG_MODE_HI:`ASU_CFG_MODE_LO];

  // unqueued mode treats each queue as one holding register
  logic [4:0] qlim;
  logic       tx_full, rx_full, tx_room, rx_half, gap_zero;
  assign qlim     = queued ? QFULL : 5'h01;
  assign tx_full  = s.txq_n >= qlim;
  assign rx_full  = s.rxq_n >= qlim;
  assign tx_room  = queued ? (s.txq_n <= (QFULL >> 1)) : (s.txq_n == 5'h00); // [RL1]
  assign rx_half  = s.rxq_n >= `ASU_RX_HALF;                                 // [RL6]
  assign gap_zero = s.gap_cnt == 8'h00;
  assign rx_head  = asu_pkg::asu_rx_entry_s'(rx_head_w);

  // event flags, bit order matches the flag register
  logic [9:0] flags;
  assign flags = {tx_full,
                  rx_half,                                      // [RL6]
                  gap_zero && s.rxq_n == 5'h00,                 // [RL7]
                  gap_zero && s.rxq_n != 5'h00,                 // [RL7]
                  s.ovr,
                  s.rxq_n != 5'h00 && rx_head.ferr,
                  s.rxq_n != 5'h00 && ((mode == `ASU_MODE_D8P && rx_head.data[8]) ||
                                       (mode == `ASU_MODE_D7P && rx_head.data[7])),
                  tx_room,                                      // [RL1]
                  s.tx_ph == asu_pkg::ASU_IDLE || s.tx_ph == asu_pkg::ASU_STOP, // [RL2]
                  s.rxq_n != 5'h00};                            // [RL3]

  assign serial_irq_out = |(flags[8:0] & s.mask);               // [RL23]
  assign pready  = ce;
  assign prdata  = s.prdata;
  assign txd     = s.txd;

  // address decode, only aligned mapped words answer without error
  logic hit;
  always_comb begin
    case (paddr)
      `ASU_OFS_BAUD, `ASU_OFS_TXHOLD, `ASU_OFS_RXHOLD, `ASU_OFS_CONFIG,
      `ASU_OFS_MASK, `ASU_OFS_FLAGS, `ASU_OFS_GAP, `ASU_OFS_TXRST,
      `ASU_OFS_RXRST: hit = 1'b1;                               // [RL25]
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  logic rxin;
  assign rxin = loop ? s.txd : rxd;

  // next-state logic for the whole unit
  always_comb begin
    logic       wr, setup, tick, tx_push, tx_pop, rx_pop, tx_line, perr, fe, ovr_set;
    logic [8:0] frame, rdat;
    logic [4:0] last;
    n       = s;
    wr      = psel && penable && pwrite && hit;
    setup   = psel && !penable;
    tick    = run && s.baud_cnt <= 16'h0001;
    tx_push = 1'b0;
    tx_pop  = 1'b0;
    rx_pop  = 1'b0;
    rx_push = 1'b0;
    rx_new  = '0;
    frame   = tx_head;
    rdat    = s.rx_sh;
    perr    = 1'b0;
    fe      = 1'b0;
    ovr_set = 1'b0;
    last    = `ASU_STOP_FIRST;
    tx_line = 1'b1;

    // baud timer, ticks at sixteen times the bit rate
    if (run) begin
      if (s.rld_pend) begin
        n.baud_cnt = s.baud_rld;                               // [RL9]
        n.rld_pend = 1'b0;
      end else if (tick) begin
        n.baud_cnt = s.baud_rld;                               // [RL22]
      end else begin
        n.baud_cnt = s.baud_cnt - 16'h0001;                    // [RL22]
      end
    end

    // transmitter; all engine state holds while run is clear
    if (run) begin
      case (s.tx_ph)
        asu_pkg::ASU_IDLE: begin
          if (s.txq_n != 5'h00) begin
            tx_pop = 1'b1;                                     // [RL1]
            case (mode)
              `ASU_MODE_D7P: frame = {1'b0, ^tx_head[6:0] ^ odd, tx_head[6:0]}; // [RL11] [RL18]
              `ASU_MODE_D8P: frame = {^tx_head[7:0] ^ odd, tx_head[7:0]};       // [RL11] [RL18]
              `ASU_MODE_D8:  frame = {1'b0, tx_head[7:0]};                      // [RL20]
              default:       frame = tx_head;                                   // [RL20]
            endcase
            n.tx_sh = frame;
            n.tx_tk = 4'h0;
            n.tx_ph = asu_pkg::ASU_START;                      // [RL10]
          end
        end
        asu_pkg::ASU_START: begin
          if (tick) begin
            n.tx_tk = s.tx_tk + 4'h1;
            if (s.tx_tk == `ASU_TICKS_LAST) begin
              n.tx_bit = 4'h0;
              n.tx_ph  = asu_pkg::ASU_DATA;
            end
          end
        end
        asu_pkg::ASU_DATA: begin
          if (tick) begin
            n.tx_tk = s.tx_tk + 4'h1;
            if (s.tx_tk == `ASU_TICKS_LAST) begin
              n.tx_sh  = s.tx_sh >> 1;
              n.tx_bit = s.tx_bit + 4'h1;
              if (s.tx_bit == (mode[2] ? 4'h8 : 4'h7)) begin   // [RL20]
                n.tx_stp = 5'h00;
                n.tx_ph  = asu_pkg::ASU_STOP;                  // [RL2]
              end
            end
          end
        end
        asu_pkg::ASU_STOP: begin
          if (tick) begin
            n.tx_stp = s.tx_stp + 5'h01;
            if (s.tx_stp == {stop_sel, 3'h7}) begin            // [RL19]
              n.tx_ph = asu_pkg::ASU_IDLE;
            end
          end
        end
        default: n.tx_ph = asu_pkg::ASU_IDLE;
      endcase
    end
    case (n.tx_ph)
      asu_pkg::ASU_START: tx_line = 1'b0;
      asu_pkg::ASU_DATA:  tx_line = n.tx_sh[0];
      default:            tx_line = 1'b1;
    endcase

    // receiver; a frame under way finishes even if reception is turned off
    if (run) begin
      case (s.rx_ph)
        asu_pkg::ASU_IDLE: begin
          if (tick && rx_on && !rxin) begin                    // [RL16]
            n.rx_tk   = 4'h0;
            n.rx_ferr = 1'b0;
            n.rx_ph   = asu_pkg::ASU_START;
          end
        end
        asu_pkg::ASU_START: begin
          if (tick) begin
            n.rx_tk = s.rx_tk + 4'h1;
            if (s.rx_tk == `ASU_TICKS_MID && rxin) begin
              n.rx_ph = asu_pkg::ASU_IDLE;                     // glitch, not a start
            end else if (s.rx_tk == `ASU_TICKS_LAST) begin
              n.rx_bit = 4'h0;
              n.rx_ph  = asu_pkg::ASU_DATA;
            end
          end
        end
        asu_pkg::ASU_DATA: begin
          if (tick) begin
            n.rx_tk = s.rx_tk + 4'h1;
            if (s.rx_tk == `ASU_TICKS_MID) begin
              n.rx_sh = {rxin, s.rx_sh[8:1]};
            end
            if (s.rx_tk == `ASU_TICKS_LAST) begin
              n.rx_bit = s.rx_bit + 4'h1;
              if (s.rx_bit == (mode[2] ? 4'h8 : 4'h7)) begin
                n.rx_stp = 5'h00;
                n.rx_ph  = asu_pkg::ASU_STOP;
              end
            end
          end
        end
        asu_pkg::ASU_STOP: begin
          // stop samples mid-bit; a half stop bit is sampled at its middle
          case (stop_sel)
            2'h0:    last = `ASU_STOP_HALF;
            2'h3:    last = `ASU_STOP_SECOND;
            default: last = `ASU_STOP_FIRST;
          endcase
          if (tick) begin
            n.rx_stp = s.rx_stp + 5'h01;
            fe = s.rx_ferr;
            if (s.rx_stp == `ASU_STOP_FIRST || s.rx_stp == last) begin
              fe = s.rx_ferr | !rxin;                          // [RL13]
            end
            n.rx_ferr = fe;
            if (s.rx_stp == last) begin
              rdat = mode[2] ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
              case (mode)
                `ASU_MODE_D7P: begin
                  perr = (^rdat[6:0] ^ odd) != rdat[7];        // [RL18]
                  rdat = {1'b0, perr, rdat[6:0]};              // [RL14]
                end
                `ASU_MODE_D8P: begin
                  perr = (^rdat[7:0] ^ odd) != rdat[8];        // [RL18]
                  rdat = {perr, rdat[7:0]};                    // [RL14]
                end
                default: rdat = rdat;                          // [RL14]
              endcase
              rx_new.ferr = fe;                                // [RL13]
              rx_new.data = rdat;
              rx_push = mode != `ASU_MODE_D8W || rdat[8];      // [RL20]
              n.rx_ph = asu_pkg::ASU_IDLE;
            end
          end
        end
        default: n.rx_ph = asu_pkg::ASU_IDLE;
      endcase
    end
    if (rx_push && rx_full) begin
      ovr_set = 1'b1;
      rx_push = 1'b0;
      n.ovr   = 1'b1;                                          // overrun wins over read clear
    end

    // read data is captured in setup so prdata comes from a flop
    if (setup) begin
      n.prdata = 32'h0000_0000;
      n.rd_ok  = 1'b0;
      case (paddr)
        `ASU_OFS_BAUD:   n.prdata[15:0] = s.baud_cnt;          // [RL8]
        `ASU_OFS_RXHOLD: begin
          n.prdata[9:0] = (s.rxq_n != 5'h00) ? rx_head : 10'h000; // [RL13]
          n.rd_ok       = s.rxq_n != 5'h00;
        end
        `ASU_OFS_CONFIG: n.prdata[15:0] = s.cfg;               // [RL25]
        `ASU_OFS_MASK:   n.prdata[8:0]  = s.mask;
        `ASU_OFS_FLAGS:  n.prdata[9:0]  = flags;
        `ASU_OFS_GAP:    n.prdata[7:0]  = s.gap_set;
        default:         n.prdata = 32'h0000_0000;
      endcase
    end

    // gap counter, reload has priority over counting down
    if (run && s.rx_ph == asu_pkg::ASU_IDLE && n.rx_ph == asu_pkg::ASU_START) begin
      n.gap_cnt = s.gap_set;                                   // [RL24]
    end else if (tick && !gap_zero) begin
      n.gap_cnt = s.gap_cnt - 8'h01;                           // [RL24]
    end

    // register writes and read side effects at the access edge
    if (psel && penable && !pwrite && paddr == `ASU_OFS_RXHOLD) begin
      n.gap_cnt = s.gap_set;                                   // [RL24]
      if (!ovr_set) begin
        n.ovr = 1'b0;
      end
      rx_pop = s.rd_ok;
    end
    if (wr) begin
      case (paddr)
        `ASU_OFS_BAUD: begin
          n.baud_rld = pwdata[15:0];                           // [RL8]
          if (run) begin
            n.baud_cnt = pwdata[15:0];                         // [RL9]
            n.rld_pend = 1'b0;
          end else begin
            n.rld_pend = 1'b1;                                 // [RL9]
          end
        end
        `ASU_OFS_TXHOLD: tx_push = !tx_full;                   // [RL10]
        `ASU_OFS_CONFIG: n.cfg   = pwdata[15:0] & `ASU_CONFIG_WMASK; // [RL25]
        `ASU_OFS_MASK:   n.mask  = pwdata[8:0];
        `ASU_OFS_GAP: begin
          n.gap_set = pwdata[7:0];
          n.gap_cnt = pwdata[7:0];                             // [RL24]
        end
        default: n.mask = n.mask;
      endcase
    end

    // queue bookkeeping; a reset write empties the queue outright
    if (tx_push) begin
      n.txq_wp = (s.txq_wp + 4'h1) & AMASK;
    end
    if (tx_pop) begin
      n.txq_rp = (s.txq_rp + 4'h1) & AMASK;
    end
    n.txq_n = s.txq_n + {4'h0, tx_push} - {4'h0, tx_pop};
    if (rx_push) begin
      n.rxq_wp = (s.rxq_wp + 4'h1) & AMASK;
    end
    if (rx_pop) begin
      n.rxq_rp = (s.rxq_rp + 4'h1) & AMASK;
    end
    n.rxq_n = s.rxq_n + {4'h0, rx_push} - {4'h0, rx_pop};
    if (wr && paddr == `ASU_OFS_TXRST) begin
      n.txq_wp = 4'h0;
      n.txq_rp = 4'h0;
      n.txq_n  = 5'h00;
    end
    if (wr && paddr == `ASU_OFS_RXRST) begin
      n.rxq_wp = 4'h0;
      n.rxq_rp = 4'h0;
      n.rxq_n  = 5'h00;
    end

    // line goes high in the same edge that run is cleared
    n.txd = n.cfg[`ASU_CFG_RUN] ? tx_line : 1'b1;             // [RL15]
  end

  // transmit queue storage
  asu_queue_mem #(.W(9), .DEPTH(DEPTH)) u_txq (
    .pclk  (pclk),
    .ce    (ce),
    .we    (psel && penable && pwrite && paddr == `ASU_OFS_TXHOLD && !tx_full),
    .waddr (s.txq_wp[$clog2(DEPTH)-1:0]),
    .wdata (pwdata[8:0]),
    .raddr (n.txq_rp[$clog2(DEPTH)-1:0]),
    .rdata (tx_head)
  );

  // receive queue storage
  asu_queue_mem #(.W(10), .DEPTH(DEPTH)) u_rxq (
    .pclk  (pclk),
    .ce    (ce),
    .we    (rx_push),
    .waddr (s.rxq_wp[$clog2(DEPTH)-1:0]),
    .wdata (rx_new),
    .raddr (n.rxq_rp[$clog2(DEPTH)-1:0]),
    .rdata (rx_head_w)
  );

  // single state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.baud_cnt <= `ASU_BAUD_RST;
      s.baud_rld <= `ASU_BAUD_RST;
      s.txd      <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// ---- src/asu_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef ASU_MAP_SVH
`define ASU_MAP_SVH
`define ASU_OFS_BAUD     12'h000
`define ASU_OFS_TXHOLD   12'h004
`define ASU_OFS_RXHOLD   12'h008
`define ASU_OFS_CONFIG   12'h00c
`define ASU_OFS_MASK     12'h010
`define ASU_OFS_FLAGS    12'h014
`define ASU_OFS_GAP      12'h01c
`define ASU_OFS_TXRST    12'h020
`define ASU_OFS_RXRST    12'h024
`define ASU_BAUD_RST     16'h0001
`define ASU_CONFIG_WMASK 16'h05ff
`define ASU_CFG_QUEUE    10
`define ASU_CFG_RXON     8
`define ASU_CFG_RUN      7
`define ASU_CFG_LOOP     6
`define ASU_CFG_ODD      5
`define ASU_CFG_STOP_HI  4
`define ASU_CFG_STOP_LO  3
`define ASU_CFG_MODE_HI  2
`define ASU_CFG_MODE_LO  0
`define ASU_MODE_D8      3'h1
`define ASU_MODE_D7P     3'h3
`define ASU_MODE_D9      3'h4
`define ASU_MODE_D8W     3'h5
`define ASU_MODE_D8P     3'h7
`define ASU_TICKS_LAST   4'hf
`define ASU_TICKS_MID    4'h7
`define ASU_STOP_HALF    5'h03
`define ASU_STOP_FIRST   5'h07
`define ASU_STOP_SECOND  5'h17
`define ASU_RX_HALF      5'h08
`endif

// ---- src/asu_pkg.sv ----
// types shared by the serial unit files
package asu_pkg;
  typedef enum logic [1:0] {ASU_IDLE, ASU_START, ASU_DATA, ASU_STOP} asu_phase_e;

  typedef struct packed {
    logic       ferr;
    logic [8:0] data;
  } asu_rx_entry_s;

  typedef struct packed {
    logic [15:0]   baud_cnt;
    logic [15:0]   baud_rld;
    logic          rld_pend;
    logic [15:0]   cfg;
    logic [8:0]    mask;
    logic [7:0]    gap_set;
    logic [7:0]    gap_cnt;
    asu_phase_e    tx_ph;
    logic [3:0]    tx_tk;
    logic [3:0]    tx_bit;
    logic [4:0]    tx_stp;
    logic [8:0]    tx_sh;
    logic          txd;
    logic [3:0]    txq_wp;
    logic [3:0]    txq_rp;
    logic [4:0]    txq_n;
    asu_phase_e    rx_ph;
    logic [3:0]    rx_tk;
    logic [3:0]    rx_bit;
    logic [4:0]    rx_stp;
    logic [8:0]    rx_sh;
    logic          rx_ferr;
    logic [3:0]    rxq_wp;
    logic [3:0]    rxq_rp;
    logic [4:0]    rxq_n;
    logic          ovr;
    logic          rd_ok;
    logic [31:0]   prdata;
  } asu_state_s;
endpackage

// ---- src/asu_queue_mem.sv ----
// small queue storage with registered, write-first read port
`timescale 1ns/1ns
`default_nettype none
module asu_queue_mem #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic                     pclk,  // bus clock
  input  wire logic                     ce,    // clock enable
  input  wire logic                     we,    // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr, // write slot
  input  wire logic [W-1:0]             wdata, // write word
  input  wire logic [$clog2(DEPTH)-1:0] raddr, // next head slot
  output logic      [W-1:0]             rdata  // head word, registered
);
  logic [W-1:0] mem [DEPTH];

  // write-first so a word pushed into the head slot is seen at once
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      if (we && waddr == raddr) begin
        rdata <= wdata;
      end else begin
        rdata <= mem[raddr];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/asu_serial_regs_properties.sv ----
// port assertions for the serial unit
`timescale 1ns/1ns
`default_nettype none
`include "asu_map.svh"
module asu_serial_regs_check (
  input wire logic        pclk,          // bus clock
  input wire logic        presetn,       // async reset, low active
  input wire logic        ce,            // clock enable
  input wire logic        psel,          // apb select
  input wire logic        penable,       // apb access
  input wire logic        pwrite,        // apb direction
  input wire logic [11:0] paddr,         // apb address
  input wire logic [31:0] pwdata,        // apb write data
  input wire logic [31:0] prdata,        // apb read data
  input wire logic        pready,        // apb ready
  input wire logic        pslverr,       // apb error
  input wire logic        rxd,           // serial in
  input wire logic        txd,           // serial out
  input wire logic        serial_irq_out // combined event line
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answers with no wait states while enabled
  a_ready_tracks_ce: assert property (pready == ce) else $error("ready differs from enable");
  a_err_only_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_err_on_hole: assert property (psel && penable && paddr == 12'h028 |-> pslverr)
    else $error("hole not refused");
  a_baud_no_err: assert property (psel && penable && paddr == `ASU_OFS_BAUD |-> !pslverr)
    else $error("baud access refused");
  // reserved upper bits read as zero
  a_rx_upper_zero: assert property (psel && penable && !pwrite && paddr == `ASU_OFS_RXHOLD
    |-> prdata[31:10] == 22'h0) else $error("receive upper bits set");
  a_cfg_resv_zero: assert property (psel && penable && !pwrite && paddr == `ASU_OFS_CONFIG
    |-> prdata[31:11] == 21'h0 && !prdata[9]) else $error("config reserved set");
  a_baud_upper_zero: assert property (psel && penable && !pwrite && paddr == `ASU_OFS_BAUD
    |-> prdata[31:16] == 16'h0) else $error("baud upper bits set");
  // a start bit spans 16 ticks, at least one clock each; the first 8 clocks are checked low
  a_start_bit_len: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
endmodule
bind asu_serial_regs asu_serial_regs_check u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .txd(txd), .serial_irq_out(serial_irq_out));
`default_nettype wire

// ---- tb/asu_remote_peer.sv ----
// remote serial peer: sends frames on rxd, captures frames from txd
`timescale 1ns/1ns
`default_nettype none
module asu_remote_peer #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic pclk, // bus clock, paces bit timing
  input  wire logic txd,  // line from the unit
  output logic      rxd   // line into the unit, idles high
);
  int         n_cap;
  logic [8:0] cap;
  int         nb;
  initial begin
    rxd = 1'b1;
    n_cap = 0;
    nb = 8;
  end
  // start, data lsb first, stop; a bad stop is released early so no false start follows
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    for (int i = -1; i < n; i++) begin
      rxd <= (i < 0) ? 1'b0 : d[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
    rxd <= stp;
    repeat (10) @(posedge pclk);
    rxd <= 1'b1;
    repeat (BIT_CLKS - 10) @(posedge pclk);
  endtask
  // capture samples mid bit, done at mid stop
  always begin
    @(negedge txd);
    cap = 9'h000;
    repeat (BIT_CLKS / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(posedge pclk);
      cap[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge pclk);
    n_cap++;
  end
endmodule
`default_nettype wire

// ---- tb/async_serial_regs_and_flags_bench.sv ----
// self-checking bench for the serial unit registers and line
`timescale 1ns/1ns
`default_nettype none
`include "asu_map.svh"
module async_serial_regs_and_flags_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [15:0] tcfg [6] = '{16'h0089, 16'h008f, 16'h00af, 16'h008b, 16'h008c, 16'h008d};
  logic [8:0]  twr  [6] = '{9'h0a5, 9'h103, 9'h003, 9'h0c1, 9'h1a5, 9'h15a};
  logic [8:0]  texp [6] = '{9'h0a5, 9'h003, 9'h103, 9'h041, 9'h1a5, 9'h15a};
  int          tnb  [6] = '{8, 9, 9, 8, 9, 9};

  asu_serial_regs u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .serial_irq_out(irq));
  asu_remote_peer u_peer (.pclk(pclk), .txd(txd), .rxd(rxd));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // bounded wait for the peer to finish n frames
  task automatic wait_cap(input int n);
    int k;
    k = 0;
    while (u_peer.n_cap < n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (u_peer.n_cap < n) n_mismatch++;
  endtask

  task automatic t_reset();
    rdchk(`ASU_OFS_BAUD, 32'h1);
    rdchk(`ASU_OFS_CONFIG, 32'h0);
    rdchk(`ASU_OFS_RXHOLD, 32'h0);
    rdchk(`ASU_OFS_FLAGS, 32'h86);
    apb(1'b0, 12'h028, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
  endtask

  // a divider write with run clear leaves the count alone
  task automatic t_baud();
    apb(1'b1, `ASU_OFS_BAUD, 32'h5);
    rdchk(`ASU_OFS_BAUD, 32'h1);
    apb(1'b1, `ASU_OFS_BAUD, 32'h1);
  endtask

  // every transmit format; loopback stays clear throughout
  task automatic t_tx();
    int n0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `ASU_OFS_CONFIG, {16'h0, tcfg[i]});
      u_peer.nb = tnb[i];
      n0 = u_peer.n_cap;
      apb(1'b1, `ASU_OFS_TXHOLD, {23'h0, twr[i]});
      apb(1'b0, `ASU_OFS_FLAGS, 32'h0);
      check(rd[2], 1'b1);
      check(rd[1], 1'b0);
      wait_cap(n0 + 1);
      check(u_peer.cap, texp[i]);
      apb(1'b0, `ASU_OFS_FLAGS, 32'h0);
      check(rd[1], 1'b1);
      repeat (16) @(posedge pclk);
    end
  endtask

  task automatic t_rx();
    apb(1'b1, `ASU_OFS_CONFIG, 32'h18c);
    // idle gap counts down from its setting once per tick
    apb(1'b1, `ASU_OFS_GAP, 32'h20);
    rdchk(`ASU_OFS_FLAGS, 32'h06);
    repeat (40) @(posedge pclk);
    rdchk(`ASU_OFS_FLAGS, 32'h86);
    apb(1'b1, `ASU_OFS_GAP, 32'h0);
    u_peer.send(9'h155, 9, 1'b1);
    rdchk(`ASU_OFS_FLAGS, 32'h47);
    rdchk(`ASU_OFS_RXHOLD, 32'h155);
    rdchk(`ASU_OFS_FLAGS, 32'h86);
    u_peer.send(9'h0aa, 9, 1'b0);
    rdchk(`ASU_OFS_RXHOLD, 32'h2aa);
    apb(1'b1, `ASU_OFS_CONFIG, 32'h18f);
    u_peer.send(9'h103, 9, 1'b1);
    rdchk(`ASU_OFS_RXHOLD, 32'h103);
    u_peer.send(9'h003, 9, 1'b1);
    rdchk(`ASU_OFS_RXHOLD, 32'h003);
    // loopback only toggled with run clear
    apb(1'b1, `ASU_OFS_CONFIG, 32'h14c);
    apb(1'b1, `ASU_OFS_CONFIG, 32'h1cc);
    apb(1'b1, `ASU_OFS_TXHOLD, 32'h1a5);
    repeat (200) @(posedge pclk);
    rdchk(`ASU_OFS_RXHOLD, 32'h1a5);
    apb(1'b1, `ASU_OFS_CONFIG, 32'h10c);
  endtask

  // half level appears at the eighth queued entry
  task automatic t_queue();
    apb(1'b1, `ASU_OFS_CONFIG, 32'h58c);
    apb(1'b1, `ASU_OFS_RXRST, 32'h0);
    for (int i = 0; i < 7; i++) u_peer.send(9'(i), 9, 1'b1);
    apb(1'b0, `ASU_OFS_FLAGS, 32'h0);
    check(rd[8], 1'b0);
    u_peer.send(9'h007, 9, 1'b1);
    apb(1'b0, `ASU_OFS_FLAGS, 32'h0);
    check(rd[8], 1'b1);
    apb(1'b1, `ASU_OFS_MASK, 32'h100);
    @(posedge pclk);
    check(irq, 1'b1);
    apb(1'b1, `ASU_OFS_MASK, 32'h0);
    @(posedge pclk);
    check(irq, 1'b0);
    rdchk(`ASU_OFS_RXHOLD, 32'h0);
    // queued transmit: sixteen, eight more at half room, then drained
    for (int i = 0; i < 16; i++) apb(1'b1, `ASU_OFS_TXHOLD, 32'(i));
    rdchk(`ASU_OFS_FLAGS, 32'h41);
    repeat (1250) @(posedge pclk);
    rdchk(`ASU_OFS_FLAGS, 32'h45);
    for (int i = 0; i < 8; i++) apb(1'b1, `ASU_OFS_TXHOLD, 32'(i));
    repeat (2980) @(posedge pclk);
    rdchk(`ASU_OFS_FLAGS, 32'h47);
  endtask

  // run clear: line held high, nothing received
  task automatic t_run_off();
    int lows;
    lows = 0;
    apb(1'b1, `ASU_OFS_CONFIG, 32'h10c);
    apb(1'b1, `ASU_OFS_RXRST, 32'h0);
    apb(1'b1, `ASU_OFS_TXHOLD, 32'h55);
    fork
      u_peer.send(9'h0f0, 9, 1'b1);
      repeat (150) begin
        @(posedge pclk);
        if (txd !== 1'b1) lows++;
      end
    join
    check(lows, 0);
    apb(1'b0, `ASU_OFS_FLAGS, 32'h0);
    check(rd[0], 1'b0);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog, well beyond the few thousand cycles the tests need
  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_baud();
    t_tx();
    t_rx();
    t_queue();
    t_run_off();
    test_done();
  end
endmodule
`default_nettype wire
